// file: include/pdl_pkg.sv
// Purpose: shared constants for the descrambler lock control block
// Assumes: 16-bit registers reached over a plain strobe port
// Notes:   offsets are register indices; byte address is not used here
package pdl_pkg;
  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 16;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [11:0] OFF_LINK_LOCK  = 12'h485;
  localparam logic [11:0] OFF_ERR_THR    = 12'h486;
  localparam logic [11:0] OFF_SLEEP      = 12'h487;
  localparam logic [11:0] OFF_STATUS     = 12'h488;
  // ------------------------------------------------------------
  // reset values and field positions
  // ------------------------------------------------------------
  localparam logic [15:0] RST_LINK_LOCK  = 16'h1078;
  localparam logic [15:0] RST_ERR_THR    = 16'h1405;
  localparam logic [15:0] RST_SLEEP      = 16'h0a00;
  localparam logic [15:0] MASK_LINK_LOCK = 16'hf1ff;
  localparam int          BIT_IPG_DIS    = 13;
  localparam int          BIT_LINK_EN    = 12;
  localparam int          IDLE_HI        = 8;
  localparam int          LOSS_HI        = 13;
  localparam int          LOSS_LO        = 9;
  localparam int          REM_HI         = 4;
  localparam int          BIT_SLEEP_EN   = 0;
  localparam int          BIT_ST_LOCK    = 0;
  localparam int          BIT_ST_REM     = 1;
  localparam int          BIT_ST_TRAIN   = 2;
  // ------------------------------------------------------------
  // lock state machine
  // ------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_HOLD   = 3'b001,
    ST_ACQ    = 3'b010,
    ST_LOCKED = 3'b100
  } pdl_state_t;
endpackage

// file: logic/pdl_sym_counter.sv
// Purpose: saturating symbol counter with threshold compare
// Assumes: count and limit share one width
// Notes:   reaching the limit is reported combinationally
`timescale 1ns/1ps
module pdl_sym_counter #(
  parameter int W = 9
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clear,
  input  wire logic         step,
  input  wire logic [W-1:0] limit,
  output logic              reached
);
  logic [W-1:0] count_ff;

  // ----------------------------------------------------------
  // counting
  // ----------------------------------------------------------
  // clear wins over step so a restart never carries an old symbol
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_ff <= '0;
    else if (clear)
      count_ff <= '0;
    else if (step && !reached)
      count_ff <= count_ff + W'(1);
  end

  assign reached = (count_ff >= limit);
endmodule // pdl_sym_counter

// file: logic/pdl_lock_control.sv
// Purpose: descrambler lock, loss of lock and remote receiver status control
// Assumes: symbol strobes from the descrambler are synchronous to clk
// Notes:   registers hold 16-bit data at index offsets
`timescale 1ns/1ps
module pdl_lock_control (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  input  wire logic        symValid,
  input  wire logic        symIdle,
  input  wire logic        inIpg,
  input  wire logic        scrLockErr,
  input  wire logic        rxSleepCode,
  input  wire logic        txSleepReq,
  output logic             trainEnable,
  output logic             linkUp,
  output logic             remRxOk,
  output logic             lockCheckActive,
  output logic             txSleepCode,
  output logic             rxSleepAccept
);
  logic [15:0]         linkLockCtl_ff;
  logic [15:0]         errThrCtl_ff;
  logic [15:0]         sleepCtl_ff;
  logic [15:0]         nxt_rdata;
  logic [15:0]         rdata_ff;
  pdl_pkg::pdl_state_t state_ff;
  pdl_pkg::pdl_state_t nxt_state;
  logic                remRx_ff;
  logic                idleReached;
  logic                lossReached;
  logic                remReached;
  logic                errSym;
  logic                idleClear;
  logic                errClear;
  logic                linkEn;
  logic                ipgDis;

  // register select shared by write and read paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------
  // register file
  // ----------------------------------------------------------
  // bits 11:9 of the lock register are read-only zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      linkLockCtl_ff <= pdl_pkg::RST_LINK_LOCK;
      errThrCtl_ff   <= pdl_pkg::RST_ERR_THR;
      sleepCtl_ff    <= pdl_pkg::RST_SLEEP;
    end
    else if (regWr)
    begin
      if (hit(regAddr, pdl_pkg::OFF_LINK_LOCK))
        linkLockCtl_ff <= regWdata & pdl_pkg::MASK_LINK_LOCK;
      if (hit(regAddr, pdl_pkg::OFF_ERR_THR))
        errThrCtl_ff <= regWdata;
      if (hit(regAddr, pdl_pkg::OFF_SLEEP))
        sleepCtl_ff <= regWdata;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    nxt_rdata = '0;
    if (hit(regAddr, pdl_pkg::OFF_LINK_LOCK))
      nxt_rdata = linkLockCtl_ff;
    else if (hit(regAddr, pdl_pkg::OFF_ERR_THR))
      nxt_rdata = errThrCtl_ff;
    else if (hit(regAddr, pdl_pkg::OFF_SLEEP))
      nxt_rdata = sleepCtl_ff;
    else if (hit(regAddr, pdl_pkg::OFF_STATUS))
    begin
      nxt_rdata[pdl_pkg::BIT_ST_LOCK]  = linkUp;
      nxt_rdata[pdl_pkg::BIT_ST_REM]   = remRx_ff;
      nxt_rdata[pdl_pkg::BIT_ST_TRAIN] = trainEnable;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= '0;
    else if (regRd)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= '0;
  end

  assign regRdata = rdata_ff;

  // ----------------------------------------------------------
  // control decode
  // ----------------------------------------------------------
  assign linkEn = linkLockCtl_ff[pdl_pkg::BIT_LINK_EN];
  assign ipgDis = linkLockCtl_ff[pdl_pkg::BIT_IPG_DIS];

  // check is masked only inside the gap, so data errors still count
  assign lockCheckActive = !(ipgDis && inIpg);
  // an error symbol: non-idle, or a scrambler check failure where checked
  assign errSym = symValid && (!symIdle || (scrLockErr && lockCheckActive));

  // ----------------------------------------------------------
  // lock state machine
  // ----------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      pdl_pkg::ST_HOLD:
        if (linkEn)
          nxt_state = pdl_pkg::ST_ACQ;
      pdl_pkg::ST_ACQ:
        if (!linkEn)
          nxt_state = pdl_pkg::ST_HOLD;
        else if (idleReached)
          nxt_state = pdl_pkg::ST_LOCKED;
      pdl_pkg::ST_LOCKED:
        if (!linkEn)
          nxt_state = pdl_pkg::ST_HOLD;
        else if (lossReached)
          nxt_state = pdl_pkg::ST_ACQ;
      default:
        nxt_state = pdl_pkg::ST_HOLD;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= pdl_pkg::ST_HOLD;
    else
      state_ff <= nxt_state;
  end

  assign trainEnable = linkEn;
  assign linkUp      = (state_ff == pdl_pkg::ST_LOCKED);

  // ----------------------------------------------------------
  // symbol counters
  // ----------------------------------------------------------
  // idle run restarts on any non-idle symbol while acquiring
  assign idleClear = (state_ff != pdl_pkg::ST_ACQ) || errSym;
  // error counts restart on entry to lock and stay cleared outside it
  assign errClear  = (state_ff != pdl_pkg::ST_LOCKED);

  pdl_sym_counter #(.W(pdl_pkg::IDLE_HI + 1)) uIdleCnt (
    .clk     (clk),
    .rst_n   (rst_n),
    .clear   (idleClear),
    .step    (symValid && symIdle),
    .limit   (linkLockCtl_ff[pdl_pkg::IDLE_HI:0]),
    .reached (idleReached)
  );

  pdl_sym_counter #(.W(pdl_pkg::LOSS_HI - pdl_pkg::LOSS_LO + 1)) uLossCnt (
    .clk     (clk),
    .rst_n   (rst_n),
    .clear   (errClear),
    .step    (errSym),
    .limit   (errThrCtl_ff[pdl_pkg::LOSS_HI:pdl_pkg::LOSS_LO]),
    .reached (lossReached)
  );

  pdl_sym_counter #(.W(pdl_pkg::REM_HI + 1)) uRemCnt (
    .clk     (clk),
    .rst_n   (rst_n),
    .clear   (errClear),
    .step    (errSym),
    .limit   (errThrCtl_ff[pdl_pkg::REM_HI:0]),
    .reached (remReached)
  );

  // ----------------------------------------------------------
  // remote receiver status
  // ----------------------------------------------------------
  // registered: high the cycle after the machine is locked and below the error limit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      remRx_ff <= 1'b0;
    else
      remRx_ff <= linkUp && !remReached;
  end

  assign remRxOk = remRx_ff;

  // ----------------------------------------------------------
  // sleep code-group gating
  // ----------------------------------------------------------
  // combinational handshake gate, no state kept here
  assign txSleepCode   = txSleepReq  && sleepCtl_ff[pdl_pkg::BIT_SLEEP_EN];
  assign rxSleepAccept = rxSleepCode && sleepCtl_ff[pdl_pkg::BIT_SLEEP_EN];

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  // a masked gap keeps scrambler failures on idles out of the error count
  AST_IPG_MASK: assert property (@(posedge clk) disable iff (!rst_n)
    (ipgDis && inIpg && symValid && symIdle) |-> !errSym)
    else $error("scrambler failure counted in gap while check disabled");

  // with link control off the machine parks in hold on the next edge
  AST_NO_TRAIN: assert property (@(posedge clk) disable iff (!rst_n)
    !linkEn |=> (state_ff == pdl_pkg::ST_HOLD))
    else $error("link progressed with link control off");

  // remote status cannot stay high once the machine is parked
  AST_HOLD_REM: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == pdl_pkg::ST_HOLD) |=> !remRxOk)
    else $error("remote status high while link held off");

  // ----------------------------------------------------------
  // checks: lock and error counting
  // ----------------------------------------------------------
  // lock comes only out of acquisition with the idle run complete
  AST_LOCK_CAUSE: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(linkUp) |-> $past(idleReached) && $past(state_ff == pdl_pkg::ST_ACQ))
    else $error("lock without idle threshold");

  // a complete idle run locks on the next edge while link control is on
  AST_LOCK_TAKEN: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == pdl_pkg::ST_ACQ && linkEn && idleReached) |=> linkUp)
    else $error("idle threshold reached but no lock");

  // below the error limit lock must be held
  AST_LOCK_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
    (linkUp && linkEn && !lossReached) |=> linkUp)
    else $error("lock lost below error threshold");

  // reaching the error limit drops lock on the next edge
  AST_LOSS: assert property (@(posedge clk) disable iff (!rst_n)
    (linkUp && linkEn && lossReached) |=> !linkUp)
    else $error("error threshold reached but lock kept");

  // a fresh lock starts from empty error counts
  AST_ERR_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(linkUp)
      |-> (!lossReached || (errThrCtl_ff[pdl_pkg::LOSS_HI:pdl_pkg::LOSS_LO] == '0)))
    else $error("error count carried into new lock");

  // remote status falls one edge after its error limit
  AST_REM_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    remReached |=> !remRxOk)
    else $error("remote status high past error limit");

  // while locked and below its limit remote status reads good
  AST_REM_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
    (linkUp && !remReached) |=> remRxOk)
    else $error("remote status low below error limit");

  // an error before the idle limit restarts the run, so no lock follows
  AST_IDLE_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == pdl_pkg::ST_ACQ && errSym && !idleReached) |=> !$rose(linkUp))
    else $error("lock declared right after non-idle symbol");

  // ----------------------------------------------------------
  // checks: register port and sleep gating
  // ----------------------------------------------------------
  // a lock register write lands with its read-only bits cleared
  AST_WR_LINK: assert property (@(posedge clk) disable iff (!rst_n)
    (regWr && hit(regAddr, pdl_pkg::OFF_LINK_LOCK))
      |=> (linkLockCtl_ff == ($past(regWdata) & pdl_pkg::MASK_LINK_LOCK)))
    else $error("lock register write did not land");

  // a threshold write lands whole on the next edge
  AST_WR_ERR: assert property (@(posedge clk) disable iff (!rst_n)
    (regWr && hit(regAddr, pdl_pkg::OFF_ERR_THR))
      |=> (errThrCtl_ff == $past(regWdata)))
    else $error("threshold register write did not land");

  // a sleep register write lands whole on the next edge
  AST_WR_SLEEP: assert property (@(posedge clk) disable iff (!rst_n)
    (regWr && hit(regAddr, pdl_pkg::OFF_SLEEP))
      |=> (sleepCtl_ff == $past(regWdata)))
    else $error("sleep register write did not land");

  // read data must not linger past its one cycle
  AST_RD_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    !regRd |=> (regRdata == 16'h0000))
    else $error("read data outside its cycle");

  // disabled sleep handling passes nothing either way
  AST_SLEEP_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    !sleepCtl_ff[pdl_pkg::BIT_SLEEP_EN] |-> !(txSleepCode || rxSleepAccept))
    else $error("sleep code-group passed while disabled");

  // enabled sleep handling follows requests in the same cycle
  AST_SLEEP_PASS: assert property (@(posedge clk) disable iff (!rst_n)
    sleepCtl_ff[pdl_pkg::BIT_SLEEP_EN]
      |-> (txSleepCode == txSleepReq) && (rxSleepAccept == rxSleepCode))
    else $error("sleep code-group blocked while enabled");
endmodule // pdl_lock_control

// file: bench/pdl_link_partner.sv
// Purpose: link partner model feeding received symbols to the lock control
// Assumes: one symbol per clk while symValid is high
// Notes:   a released qualifier is inverted so no stale value looks valid
`timescale 1ns/1ps
module pdl_link_partner (
  input  wire logic clk,
  output logic      symValid,
  output logic      symIdle,
  output logic      scrLockErr,
  output logic      inIpg,
  output logic      rxSleepCode
);
  // quiet line at time zero
  initial
  begin
    symValid    = 1'b0;
    symIdle     = 1'b0;
    scrLockErr  = 1'b0;
    inIpg       = 1'b0;
    rxSleepCode = 1'b0;
  end
  // burst of n idle or error symbols, then release the line
  task automatic send(input int n, input logic idle);
    repeat (n)
    begin
      @(posedge clk);
      symValid <= 1'b1;
      symIdle  <= idle;
    end
    @(posedge clk);
    symValid <= 1'b0;
    symIdle  <= ~idle; // not a symbol any more
  endtask
  // gap, sleep code-group and scrambler check levels seen on the wire
  task automatic setLine(input logic gap, input logic sleep, input logic err);
    @(posedge clk);
    inIpg       <= gap;
    rxSleepCode <= sleep;
    scrLockErr  <= err;
  endtask
endmodule // pdl_link_partner

// file: bench/tb_top.sv
// Purpose: self-checking bench for the descrambler lock control
// Assumes: register port answers one cycle after the read strobe
// Notes:   idle limit cut to 3 so lock comes quickly
`timescale 1ns/1ps
module tb_top;
  logic        clk;
  logic        rst_n;
  logic [11:0] regAddr;
  logic [15:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [15:0] regRdata;
  logic        symValid;
  logic        symIdle;
  logic        inIpg;
  logic        scrLockErr;
  logic        rxSleepCode;
  logic        txSleepReq;
  logic        trainEnable;
  logic        linkUp;
  logic        remRxOk;
  logic        lockCheckActive;
  logic        txSleepCode;
  logic        rxSleepAccept;
  int          fail_count;
  int          cmp_count;
  int          cycleCount;

  pdl_lock_control u_pdl_lock_control (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .symValid(symValid), .symIdle(symIdle), .inIpg(inIpg), .scrLockErr(scrLockErr),
    .rxSleepCode(rxSleepCode), .txSleepReq(txSleepReq), .trainEnable(trainEnable),
    .linkUp(linkUp), .remRxOk(remRxOk), .lockCheckActive(lockCheckActive),
    .txSleepCode(txSleepCode), .rxSleepAccept(rxSleepAccept));
  pdl_link_partner u_pdl_link_partner (.clk(clk), .symValid(symValid), .symIdle(symIdle),
    .scrLockErr(scrLockErr), .inIpg(inIpg), .rxSleepCode(rxSleepCode));

  // ------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ceiling far above the hundred or so cycles the tests need
  always @(posedge clk)
  begin
    cycleCount++;
    if (cycleCount == 5000)
    begin
      fail_count++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd   <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0; regAddr = 12'h000; regWdata = 16'h0000;
    regWr = 1'b0; regRd = 1'b0; txSleepReq = 1'b0;
    fail_count = 0; cmp_count = 0; cycleCount = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(pdl_pkg::OFF_LINK_LOCK, 16'h1078);
    rd(pdl_pkg::OFF_ERR_THR, 16'h1405);
    rd(pdl_pkg::OFF_SLEEP, 16'h0a00);
    rd(12'h480, 16'h0000);
    wr(pdl_pkg::OFF_LINK_LOCK, 16'hffff);
    rd(pdl_pkg::OFF_LINK_LOCK, 16'hf1ff);
    // gap check follows bit 13 only while in the gap
    wr(pdl_pkg::OFF_LINK_LOCK, 16'h1003);
    txSleepReq <= 1'b1;
    u_pdl_link_partner.setLine(1'b1, 1'b1, 1'b0);
    settle();
    chk(lockCheckActive, 1'b1);
    chk({txSleepCode, rxSleepAccept}, 2'b00);
    wr(pdl_pkg::OFF_LINK_LOCK, 16'h3003);
    wr(pdl_pkg::OFF_SLEEP, 16'h0001);
    settle();
    chk(lockCheckActive, 1'b0);
    chk({txSleepCode, rxSleepAccept}, 2'b11);
    u_pdl_link_partner.setLine(1'b0, 1'b0, 1'b0);
    settle();
    chk(lockCheckActive, 1'b1);
    // lock needs 3 idles in a row; an error restarts the count
    wr(pdl_pkg::OFF_ERR_THR, 16'h0602);
    u_pdl_link_partner.send(2, 1'b1);
    u_pdl_link_partner.send(1, 1'b0);
    u_pdl_link_partner.send(2, 1'b1);
    settle();
    chk(linkUp, 1'b0);
    u_pdl_link_partner.send(1, 1'b1);
    settle();
    chk({linkUp, remRxOk}, 2'b11);
    rd(pdl_pkg::OFF_STATUS, 16'h0007);
    // scrambler failures inside a masked gap are not errors
    u_pdl_link_partner.setLine(1'b1, 1'b0, 1'b1);
    u_pdl_link_partner.send(3, 1'b1);
    settle();
    chk({linkUp, remRxOk}, 2'b11);
    // remote status drops after 2 errors, lock after 3
    u_pdl_link_partner.setLine(1'b0, 1'b0, 1'b1);
    u_pdl_link_partner.send(1, 1'b1);
    u_pdl_link_partner.setLine(1'b0, 1'b0, 1'b0);
    u_pdl_link_partner.send(1, 1'b0);
    settle();
    chk({linkUp, remRxOk}, 2'b10);
    u_pdl_link_partner.send(1, 1'b0);
    settle();
    chk(linkUp, 1'b0);
    // clearing link control blocks training and lock
    wr(pdl_pkg::OFF_LINK_LOCK, 16'h0003);
    u_pdl_link_partner.send(4, 1'b1);
    settle();
    chk({trainEnable, linkUp}, 2'b00);
    stop_test();
  end
endmodule // tb_top
